// ==== src/bpm_host.v ====
// Host controller that writes boot stage codes into the progress monitor
`timescale 1ns/100ps
`include "bpm_defs.vh"
module bpm_host (
  // Clock and reset
  input wire clk_sys,
  input wire rstn,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // Code write port toward the device
  output reg codeWe,
  output reg [15:0] codeOut,
  // Device state pins
  input wire [15:0] bootStageCode,
  input wire wdogOn,
  input wire trapOn,
  input wire cfgAlarm
);
  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  wire [18:0] pinSync;

  bpm_sync #(
    .W(19)
  ) u_sync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .pinIn({cfgAlarm, trapOn, wdogOn, bootStageCode}),
    .pinOut(pinSync)
  );

  wire devWdog = pinSync[16];
  wire devTrap = pinSync[17];
  wire devAlarm = pinSync[18];

  // --------------------------------------------------------------------------
  // Code word qualifier
  // --------------------------------------------------------------------------
  // The code bits pass the synchroniser one by one, so a change on the pins can
  // show a torn word for an edge. A word is taken only when two edges in a row
  // agree; that adds two cycles to every readback, and in return a torn value
  // can never match an event code or stand in for a pending acknowledge.
  reg [15:0] codeSeen_q;
  reg [15:0] codeStable_q;

  wire [15:0] devCode = codeStable_q;

  always @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      codeSeen_q <= `BPM_RST_CODE;
      codeStable_q <= `BPM_RST_CODE;
    end
    else
    begin
      codeSeen_q <= pinSync[15:0];
      if (pinSync[15:0] == codeSeen_q)
      begin
        codeStable_q <= codeSeen_q;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Bus slave: zero wait states, always OKAY
  // --------------------------------------------------------------------------
  // Reads are captured in the address phase, so a read placed straight after a
  // write to the same register still returns the value from before that write
  reg wrPend_q;
  reg [7:0] wrAddr_q;
  wire addrPhase = hsel && hready && htrans[1];
  wire doWrite = wrPend_q;
  wire [31:0] wdata = hwdata;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 8'h00;
    end
    else
    begin
      wrPend_q <= addrPhase && hwrite;
      wrAddr_q <= haddr[7:0];
    end
  end

  // --------------------------------------------------------------------------
  // Software registers
  // --------------------------------------------------------------------------
  reg [1:0] ctrl_q;
  reg [15:0] ackLimit_q;
  reg [15:0] lastCode_q;
  reg [`BPM_EV_W-1:0] events_q;
  reg reject_q;
  reg ackTmo_q;
  reg selftest_q;
  reg drvAttached_q;
  reg clientsLoaded_q;
  reg pendReq_q;

  wire wrCtrl = doWrite && (wrAddr_q == `BPM_OFS_CTRL);
  wire wrCode = doWrite && (wrAddr_q == `BPM_OFS_WRCODE);
  wire wrEvents = doWrite && (wrAddr_q == `BPM_OFS_EVENTS);
  wire wrTimeout = doWrite && (wrAddr_q == `BPM_OFS_TIMEOUT);
  wire cancelReq = wrCtrl && wdata[`BPM_CTRL_CANCEL];

  // --------------------------------------------------------------------------
  // Request check
  // --------------------------------------------------------------------------
  wire [15:0] reqCode = cancelReq ? `BPM_CODE_CLIENTS_ON : wdata[15:0];
  wire inRange;
  wire srcAlloc;
  wire stStep;
  wire reqErr;

  bpm_code_class u_class (
    .code(reqCode),
    .inRange(inRange),
    .srcAllocated(srcAlloc),
    .selftestStep(stStep),
    .errDigit(reqErr)
  );

  // The F digit belongs to the controller; a strict host sends it only in the dead code 1FFF
  wire strictBad = ctrl_q[`BPM_CTRL_STRICT] &&
                   ((stStep && !selftest_q) || (reqErr && reqCode != `BPM_CODE_DEAD));
  wire reqValid = inRange && srcAlloc && !strictBad;
  wire reqAny = wrCode || cancelReq;

  // --------------------------------------------------------------------------
  // Write sequencer
  // --------------------------------------------------------------------------
  localparam S_IDLE = 2'b00;
  localparam S_DRIVE = 2'b01;
  localparam S_WAIT = 2'b10;

  reg [1:0] state_q;
  reg [15:0] ackCnt_q;
  wire busy = (state_q != S_IDLE);
  wire accept = reqAny && !busy && reqValid;
  // The device shows the written code once it takes it, so readback equality is the ack
  wire acked = (state_q == S_WAIT) && (devCode == lastCode_q);
  wire ackTimeout = (state_q == S_WAIT) && !acked && (ackCnt_q >= ackLimit_q);

  always @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      state_q <= S_IDLE;
      codeWe <= 1'b0;
      codeOut <= `BPM_RST_CODE;
      lastCode_q <= `BPM_RST_CODE;
      ackCnt_q <= 16'h0000;
    end
    else
    begin
      codeWe <= 1'b0;
      case (state_q)
        S_IDLE:
        begin
          ackCnt_q <= 16'h0000;
          if (accept)
          begin
            codeWe <= 1'b1;
            codeOut <= reqCode;
            lastCode_q <= reqCode;
            state_q <= S_DRIVE;
          end
        end
        S_DRIVE:
        begin
          state_q <= S_WAIT;
        end
        S_WAIT:
        begin
          ackCnt_q <= ackCnt_q + 16'h0001;
          if (acked || ackTimeout)
          begin
            state_q <= S_IDLE;
          end
        end
        default:
        begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Boot progress tracking
  // --------------------------------------------------------------------------
  always @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      ctrl_q <= `BPM_RST_CTRL;
      ackLimit_q <= `BPM_RST_TIMEOUT;
      reject_q <= 1'b0;
      ackTmo_q <= 1'b0;
      selftest_q <= 1'b0;
      drvAttached_q <= 1'b0;
      clientsLoaded_q <= 1'b0;
    end
    else
    begin
      if (wrCtrl)
      begin
        ctrl_q <= {1'b0, wdata[`BPM_CTRL_STRICT]};
      end
      if (wrTimeout)
      begin
        ackLimit_q <= wdata[15:0];
      end
      if (reqAny)
      begin
        reject_q <= !accept;
      end
      if (accept)
      begin
        ackTmo_q <= 1'b0;
      end
      else if (ackTimeout)
      begin
        ackTmo_q <= 1'b1;
      end
      if (accept)
      begin
        case (reqCode)
          `BPM_CODE_ST_BEGIN: selftest_q <= 1'b1;
          `BPM_CODE_ST_DONE: selftest_q <= 1'b0;
          `BPM_CODE_DRV_OFF: drvAttached_q <= 1'b0;
          `BPM_CODE_DRV_ON: drvAttached_q <= 1'b1;
          `BPM_CODE_CLIENTS_OFF: clientsLoaded_q <= 1'b0;
          `BPM_CODE_CLIENTS_ON: clientsLoaded_q <= !cancelReq;
          default: selftest_q <= selftest_q;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // Controller-posted codes, watchdog drops and trap pin changes seen on the readback
  // --------------------------------------------------------------------------
  reg [15:0] prevCode_q;
  reg prevWdog_q;
  reg prevTrap_q;
  wire codeNew = (devCode != prevCode_q);
  reg [`BPM_EV_W-1:0] evSet;

  always @*
  begin
    evSet = {`BPM_EV_W{1'b0}};
    evSet[`BPM_EV_CFGLOST] = codeNew && (devCode == `BPM_CODE_CFG_LOST) && devAlarm;
    evSet[`BPM_EV_DPRESET] = codeNew && (devCode == `BPM_CODE_DP_RESET);
    // Only a late self-test start shows here; the device owns the timer
    evSet[`BPM_EV_STTMO] = codeNew && (devCode == `BPM_CODE_ST_TMO);
    evSet[`BPM_EV_SHUTDN] = codeNew && (devCode == `BPM_CODE_SHUTDN);
    evSet[`BPM_EV_RSTREQ] = codeNew && (devCode == `BPM_CODE_RSTREQ);
    evSet[`BPM_EV_NMI] = codeNew && (devCode == `BPM_CODE_NMI);
    evSet[`BPM_EV_DUMP] = codeNew && (devCode == `BPM_CODE_DUMP);
    evSet[`BPM_EV_DEAD] = codeNew && (devCode == `BPM_CODE_DEAD);
    evSet[`BPM_EV_WDOGOFF] = prevWdog_q && !devWdog;
    evSet[`BPM_EV_TRAPCHG] = prevTrap_q != devTrap;
  end

  always @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      prevCode_q <= `BPM_RST_CODE;
      prevWdog_q <= 1'b0;
      prevTrap_q <= 1'b0;
      events_q <= {`BPM_EV_W{1'b0}};
      pendReq_q <= 1'b0;
    end
    else
    begin
      prevCode_q <= devCode;
      prevWdog_q <= devWdog;
      prevTrap_q <= devTrap;
      // Set wins over a write-one-to-clear in the same cycle
      events_q <= (events_q & ~(wrEvents ? wdata[`BPM_EV_W-1:0] : {`BPM_EV_W{1'b0}})) | evSet;
      if (evSet[`BPM_EV_SHUTDN] || evSet[`BPM_EV_RSTREQ])
      begin
        pendReq_q <= 1'b1;
      end
      else if (accept && cancelReq)
      begin
        pendReq_q <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Read data, registered in the address phase
  // --------------------------------------------------------------------------
  wire [15:0] status = {5'h00, pendReq_q, devCode[3:0] == `BPM_ERR_DIGIT, devAlarm,
                        devTrap, devWdog, clientsLoaded_q, drvAttached_q, selftest_q,
                        ackTmo_q, reject_q, busy};
  reg [31:0] rdMux;

  always @*
  begin
    case (haddr[7:0])
      `BPM_OFS_CTRL: rdMux = {30'h0, ctrl_q};
      `BPM_OFS_WRCODE: rdMux = {16'h0000, lastCode_q};
      `BPM_OFS_STATUS: rdMux = {16'h0000, status};
      `BPM_OFS_EVENTS: rdMux = {22'h0, events_q};
      `BPM_OFS_CURCODE: rdMux = {16'h0000, devCode};
      `BPM_OFS_TIMEOUT: rdMux = {16'h0000, ackLimit_q};
      default: rdMux = 32'h00000000;
    endcase
  end

  always @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      hrdata <= 32'h00000000;
    end
    else if (addrPhase && !hwrite)
    begin
      hrdata <= rdMux;
    end
  end
endmodule

// ==== src/bpm_defs.vh ====
// Constants shared by the boot progress monitor host controller
`ifndef BPM_DEFS_VH
`define BPM_DEFS_VH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define BPM_OFS_CTRL 8'h00
`define BPM_OFS_WRCODE 8'h04
`define BPM_OFS_STATUS 8'h08
`define BPM_OFS_EVENTS 8'h0c
`define BPM_OFS_CURCODE 8'h10
`define BPM_OFS_TIMEOUT 8'h14

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define BPM_CTRL_STRICT 0
`define BPM_CTRL_CANCEL 1
`define BPM_ST_BUSY 0
`define BPM_ST_REJECT 1
`define BPM_ST_ACKTMO 2
`define BPM_ST_SELFTEST 3
`define BPM_ST_DRVATT 4
`define BPM_ST_CLILOAD 5
`define BPM_ST_WDOG 6
`define BPM_ST_TRAP 7
`define BPM_ST_ALARM 8
`define BPM_ST_ERRDIG 9
`define BPM_ST_PENDREQ 10
`define BPM_EV_CFGLOST 0
`define BPM_EV_DPRESET 1
`define BPM_EV_STTMO 2
`define BPM_EV_SHUTDN 3
`define BPM_EV_RSTREQ 4
`define BPM_EV_NMI 5
`define BPM_EV_DUMP 6
`define BPM_EV_DEAD 7
`define BPM_EV_WDOGOFF 8
`define BPM_EV_TRAPCHG 9
`define BPM_EV_W 10

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define BPM_RST_CTRL 2'h1
`define BPM_RST_TIMEOUT 16'h0064
`define BPM_RST_CODE 16'h0000

// ----------------------------------------------------------------------------
// Boot stage codes
// ----------------------------------------------------------------------------
`define BPM_CODE_CLIENTS_ON 16'h0000
`define BPM_CODE_CFG_LOST 16'h0001
`define BPM_CODE_DP_RESET 16'h1000
`define BPM_CODE_ST_TMO 16'h100f
`define BPM_CODE_SHUTDN 16'h1200
`define BPM_CODE_RSTREQ 16'h1400
`define BPM_CODE_NMI 16'h1600
`define BPM_CODE_DUMP 16'h1800
`define BPM_CODE_DEAD 16'h1fff
`define BPM_CODE_ST_BEGIN 16'h2000
`define BPM_CODE_ST_LAST 16'h2fff
`define BPM_CODE_ST_DONE 16'h7ff0
`define BPM_CODE_DRV_OFF 16'h8fe0
`define BPM_CODE_DRV_ON 16'h8ff0
`define BPM_CODE_CLIENTS_OFF 16'hffe0
`define BPM_CODE_MIN 16'h1000
`define BPM_ERR_DIGIT 4'hf

`endif

// ==== src/bpm_sync.v ====
// Two-stage synchroniser for pins arriving from the device
`timescale 1ns/100ps
module bpm_sync #(
  parameter W = 1
) (
  // Clock and reset
  input wire clk_sys,
  input wire rstn,
  // Data
  input wire [W-1:0] pinIn,
  output reg [W-1:0] pinOut
);
  reg [W-1:0] meta_q;

  always @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      meta_q <= {W{1'b0}};
      pinOut <= {W{1'b0}};
    end
    else
    begin
      meta_q <= pinIn;
      pinOut <= meta_q;
    end
  end
endmodule

// ==== src/bpm_code_class.v ====
// Classifier for a boot stage code: range, source and error digit
`timescale 1ns/100ps
`include "bpm_defs.vh"
module bpm_code_class (
  // Code under test
  input wire [15:0] code,
  // Classification
  output wire inRange,
  output wire srcAllocated,
  output wire selftestStep,
  output wire errDigit
);
  wire [3:0] top = code[15:12];

  assign inRange = (code >= `BPM_CODE_MIN) || (code == `BPM_CODE_CLIENTS_ON);
  // 400-7FF and 900-EFF carry no source; the completion code is the exception
  assign srcAllocated = (top == 4'h1) || (top == 4'h2) || (top == 4'h3) ||
                        (top == 4'h8) || (top == 4'hf) ||
                        (code == `BPM_CODE_ST_DONE) ||
                        (code == `BPM_CODE_CLIENTS_ON);
  assign selftestStep = (code > `BPM_CODE_ST_BEGIN) && (code <= `BPM_CODE_ST_LAST);
  assign errDigit = (code[3:0] == `BPM_ERR_DIGIT);
endmodule

// ==== verification/bpm_host_checker.sv ====
// Concurrent checks on the ports of the boot progress monitor host controller
`timescale 1ns/100ps
module bpm_host_checker (
  // Clock and reset
  input wire clk_sys,
  input wire rstn,
  // Bus side
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  // Device side
  input wire codeWe,
  input wire [15:0] codeOut,
  input wire wdogOn,
  input wire trapOn
);
  reg phWr_q;
  reg phRd_q;
  reg [7:0] adr_q;
  reg [1:0] pins_q;
  reg [3:0] pinAge_q;
  wire take = hsel & hready & htrans[1];
  // ----
  // Phase tracking; pin age keeps status reads clear of the synchroniser lag
  // ----
  always @(posedge clk_sys)
  begin
    phWr_q <= take & hwrite;
    phRd_q <= take & ~hwrite;
    adr_q <= haddr[7:0];
    pins_q <= {trapOn, wdogOn};
    if (!rstn || pins_q != {trapOn, wdogOn})
      pinAge_q <= 4'h0;
    else if (pinAge_q != 4'hf)
      pinAge_q <= pinAge_q + 4'h1;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus stalled or erred");
  a_we_cause: assert property (codeWe |-> $past(phWr_q) && ($past(adr_q) == 8'h04 ?
    codeOut == $past(hwdata[15:0]) : $past(adr_q) == 8'h00 && codeOut == 16'h0000))
    else $error("code strobe without matching write");
  a_we_gap: assert property (codeWe |=> (!codeWe) [*2])
    else $error("code strobes too close");
  a_code_legal: assert property (codeWe |-> codeOut inside {16'h0000, [16'h1000:16'h3fff],
    16'h7ff0, [16'h8000:16'h8fff], [16'hf000:16'hffff]})
    else $error("code out of range or from unallocated source");
  a_err_digit: assert property (codeWe |-> codeOut[3:0] != 4'hf || codeOut == 16'h1fff)
    else $error("error digit sent by host");
  a_code_hold: assert property (!codeWe |-> $stable(codeOut))
    else $error("code changed without strobe");
  a_read_code: assert property (phRd_q && adr_q == 8'h04 |-> hrdata[15:0] == codeOut)
    else $error("readback differs from issued code");
  a_pin_status: assert property (phRd_q && adr_q == 8'h08 && pinAge_q > 4'h7
    |-> hrdata[7:6] == {trapOn, wdogOn})
    else $error("status does not follow device pins");
endmodule

bind bpm_host bpm_host_checker i_chk (.clk_sys, .rstn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .hready, .hreadyout, .hresp, .hrdata, .codeWe, .codeOut, .wdogOn, .trapOn);

// ==== verification/bpm_dev_model.sv ====
// Behavioural model of the progress monitor device behind the host controller
`timescale 1ns/100ps
module bpm_dev_model (
  // Clock and reset
  input wire clk_sys,
  input wire rstn,
  // Code write port
  input wire codeWe,
  input wire [15:0] codeOut,
  // Device state pins
  output reg [15:0] bootStageCode,
  output reg wdogOn,
  output reg trapOn,
  output reg cfgAlarm,
  // Bench controls
  input wire [3:0] ackDelay,
  input wire mute,
  input wire postEn,
  input wire [15:0] postCode
);
  reg [15:0] pend;
  reg [3:0] lag;
  reg busy;
  reg upd;
  reg [15:0] nxt;
  // A muted model drops writes so the host's acknowledge time-out can be reached
  always @(posedge clk_sys)
  begin
    upd = 1'b0;
    nxt = postCode;
    if (!rstn)
    begin
      bootStageCode <= 16'h0000;
      wdogOn <= 1'b1;
      trapOn <= 1'b0;
      cfgAlarm <= 1'b0;
      busy <= 1'b0;
    end
    else
    begin
      if (codeWe && !mute)
      begin
        busy <= 1'b1;
        pend <= codeOut;
        lag <= ackDelay;
      end
      else if (busy && lag != 4'h0)
        lag <= lag - 4'h1;
      else if (busy)
      begin
        busy <= 1'b0;
        upd = 1'b1;
        nxt = pend;
      end
      if (postEn)
        nxt = postCode;
      if (postEn || upd)
      begin
        bootStageCode <= nxt;
        if (nxt == 16'h7ff0)
          wdogOn <= 1'b0;
        if (nxt == 16'hffe0)
          trapOn <= 1'b0;
        if (nxt == 16'h0000)
          trapOn <= 1'b1;
        if (nxt == 16'h0001)
          cfgAlarm <= 1'b1;
      end
    end
  end
endmodule

// ==== verification/bpm_host_test.sv ====
// Self-checking testbench for the boot progress monitor host controller
`timescale 1ns/100ps
module bpm_host_test;
  localparam [31:0] ALL = 32'hffffffff;
  localparam [223:0] LEGAL = {16'h2000, 16'h0048, 16'h2abc, 16'h0048, 16'h7ff0, 16'h0000,
    16'h8ff0, 16'h0010, 16'h0000, 16'h0090, 16'hffe0, 16'h0010, 16'h8fe0, 16'h0000};
  localparam [111:0] BAD = {16'h0abc, 16'h4120, 16'h7fff, 16'h9000, 16'he120, 16'h123f,
    16'h2005};
  localparam [111:0] POSTS = {16'h0001, 16'h1000, 16'h100f, 16'h1200, 16'h1400, 16'h1600,
    16'h1800};
  reg clk_sys = 1'b0;
  reg rstn = 1'b0;
  reg hsel = 1'b0;
  reg [31:0] haddr = 32'h0;
  reg [1:0] htrans = 2'h0;
  reg hwrite = 1'b0;
  reg [31:0] hwdata = 32'h0;
  reg [3:0] ackDelay = 4'h0;
  reg mute = 1'b0;
  reg postEn = 1'b0;
  reg [15:0] postCode = 16'h0;
  wire hready;
  wire hresp;
  wire [31:0] hrdata;
  wire codeWe;
  wire [15:0] codeOut;
  wire [15:0] bootStageCode;
  wire wdogOn;
  wire trapOn;
  wire cfgAlarm;
  integer n_mismatch = 0;
  integer comparisons = 0;
  integer i;
  reg [31:0] rd;
  reg [31:0] ent;
  always #5 clk_sys = ~clk_sys;
  bpm_host i_dut (.clk_sys, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready, .hreadyout(hready), .hresp, .hrdata, .codeWe, .codeOut, .bootStageCode,
    .wdogOn, .trapOn, .cfgAlarm);
  bpm_dev_model i_dev (.clk_sys, .rstn, .codeWe, .codeOut, .bootStageCode, .wdogOn,
    .trapOn, .cfgAlarm, .ackDelay, .mute, .postEn, .postCode);
  // ----
  // Bus tasks
  // ----
  task chk(input [31:0] seen, input [31:0] exp);
  begin
    comparisons = comparisons + 1;
    if (seen !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  end
  endtask
  task xfer(input wr, input [7:0] a, input [31:0] d);
  begin
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    @(posedge clk_sys);
    while (hready !== 1'b1)
      @(posedge clk_sys);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk_sys);
    while (hready !== 1'b1)
      @(posedge clk_sys);
    rd = hrdata;
  end
  endtask
  task rdchk(input [7:0] a, input [31:0] m, input [31:0] e);
  begin
    xfer(1'b0, a, 32'h0);
    chk(rd & m, e);
  end
  endtask
  // Polls busy, then lets the pins pass the synchroniser before anything is read
  task settle;
    integer k;
  begin
    rd = 32'h1;
    for (k = 0; k < 40 && rd[0] !== 1'b0; k = k + 1)
      xfer(1'b0, 8'h08, 32'h0);
    chk(rd & 32'h1, 32'h0);
    repeat (8) @(posedge clk_sys);
  end
  endtask
  task put(input [15:0] c);
  begin
    xfer(1'b1, 8'h04, {16'h0, c});
    settle;
  end
  endtask
  task power_on_selftest(input [15:0] c);
  begin
    postCode <= c;
    postEn <= 1'b1;
    @(posedge clk_sys);
    postEn <= 1'b0;
    repeat (8) @(posedge clk_sys);
  end
  endtask
  task wrap_up;
  begin
    $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end
  endtask
  // ----
  // Scenarios
  // ----
  initial
  begin
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    hsel <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rdchk(8'h14, ALL, 32'h64);
    rdchk(8'h08, ALL, 32'h40);
    xfer(1'b1, 8'h20, ALL);
    rdchk(8'h20, ALL, 32'h0);
    for (i = 0; i < 7; i = i + 1)
    begin
      ent = LEGAL[32*(6-i) +: 32];
      put(ent[31:16]);
      rdchk(8'h10, ALL, {16'h0, ent[31:16]});
      rdchk(8'h08, 32'h3db, {16'h0, ent[15:0]});
    end
    rdchk(8'h0c, ALL, 32'h300);
    for (i = 0; i < 7; i = i + 1)
    begin
      put(BAD[16*(6-i) +: 16]);
      rdchk(8'h08, 32'h2, 32'h2);
      rdchk(8'h10, ALL, 32'h8fe0);
    end
    xfer(1'b1, 8'h04, 32'h3110);
    put(16'h3120);
    rdchk(8'h08, 32'h2, 32'h2);
    rdchk(8'h10, ALL, 32'h3110);
    xfer(1'b1, 8'h0c, ALL);
    put(16'h1fff);
    for (i = 0; i < 7; i = i + 1)
      power_on_selftest(POSTS[16*(6-i) +: 16]);
    rdchk(8'h0c, ALL, 32'hff);
    power_on_selftest(16'h100f);
    rdchk(8'h08, 32'h700, 32'h700);
    xfer(1'b1, 8'h0c, ALL);
    rdchk(8'h0c, 32'h7f, 32'h0);
    xfer(1'b1, 8'h00, 32'h3);
    settle;
    rdchk(8'h04, ALL, 32'h0);
    rdchk(8'h10, ALL, 32'h0);
    rdchk(8'h08, 32'h420, 32'h0);
    put(16'h3130);
    rdchk(8'h04, ALL, 32'h3130);
    xfer(1'b1, 8'h00, 32'h0);
    put(16'h2005);
    rdchk(8'h10, ALL, 32'h2005);
    xfer(1'b1, 8'h00, 32'h1);
    xfer(1'b1, 8'h14, 32'ha);
    ackDelay <= 4'h4;
    put(16'h3200);
    rdchk(8'h08, 32'h4, 32'h0);
    rdchk(8'h10, ALL, 32'h3200);
    mute <= 1'b1;
    put(16'h3210);
    rdchk(8'h08, 32'h5, 32'h4);
    rdchk(8'h10, ALL, 32'h3200);
    wrap_up;
  end
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch = n_mismatch + 1;
    wrap_up;
  end
endmodule
